// ===== hdl/spo_ctrl.sv
// synthesizer pin override, trim and calibration hold control
`timescale 1ns/10ps
`default_nettype none
module spo_ctrl
  import spo_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // register port from the serial interface
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  // configuration pins, asynchronous
  input  wire logic              pll_enable_pin,
  input  wire logic              ref_select_pin,
  input  wire logic              clock_config_pin_zero,
  input  wire logic              clock_config_pin_one,
  // calibration engine
  input  wire logic              calibration_enable,
  input  wire logic              cal_trim_load,
  input  wire logic [TRIM_W-1:0] cal_trim_value,
  input  wire logic              cal_finished,
  output logic                   calibration_start,
  output logic                   calibration_done,
  // synthesizer controls
  output logic                   synth_enable,
  output logic                   single_ended_ref_select,
  output logic      [1:0]        first_divided_refout_mode,
  output logic      [1:0]        second_divided_refout_mode,
  output logic                   synth_hold,
  output logic      [TRIM_W-1:0] vco_trim_out
);

  logic [PIN_W-1:0] sync1_q, sync2_q;
  logic [7:0]       ovr_q, ovr_d, trim_q, trim_d, hold_q, hold_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             rvalid_q, rvalid_d;
  spo_cal_t         cal_q, cal_d;
  logic             start_q, start_d;
  logic             en_q, en_d, se_q, se_d, hold_out_q;
  logic [1:0]       first_q, first_d, second_q, second_d;
  logic             wr_ovr, wr_trim, wr_hold, ovr_en;
  logic [1:0]       pin_mode, first_fld, second_fld;

  // pins cross two flops before anything looks at them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= PIN_RST;
      sync2_q <= PIN_RST;
    end else begin
      sync1_q <= {clock_config_pin_one, clock_config_pin_zero,
                  ref_select_pin, pll_enable_pin};
      sync2_q <= sync1_q;
    end
  end

  assign wr_ovr     = reg_wr && (reg_addr == ADDR_OVR);
  assign wr_trim    = reg_wr && (reg_addr == ADDR_TRIM);
  assign wr_hold    = reg_wr && (reg_addr == ADDR_HOLD);
  assign ovr_en     = ovr_q[OVR_EN_BIT];
  assign first_fld  = ovr_q[FIRST_LSB +: 2];
  assign second_fld = ovr_q[SEC_LSB +: 2];
  // pin mode: both outputs follow the two-pin code
  assign pin_mode   = {sync2_q[PIN_CFG1], sync2_q[PIN_CFG0]};

  // register file; reserved bits are stored and read back as written
  always_comb begin
    ovr_d  = ovr_q;
    trim_d = trim_q;
    hold_d = hold_q;
    if (wr_ovr) begin
      ovr_d = reg_wdata;
    end
    // engine load wins over a software write that breaks the hands-off
    if (cal_trim_load && cal_q == CAL_RUN) begin
      trim_d = {trim_q[7], cal_trim_value};
    end else if (wr_trim) begin
      trim_d = reg_wdata;
    end
    if (wr_hold) begin
      hold_d = reg_wdata;
    end
  end

  // reads are side-effect free; unmapped addresses answer zero
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d  = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_OVR:  rdata_d = ovr_q;
        ADDR_TRIM: rdata_d = trim_q;
        ADDR_HOLD: rdata_d = hold_q;
        default:   rdata_d = RD_UNMAP;
      endcase
    end
  end

  // calibration sequencing
  always_comb begin
    cal_d = cal_q;
    if (wr_hold) begin
      if (reg_wdata[HOLD_BIT]) begin
        cal_d = CAL_IDLE;
      end else if (calibration_enable) begin
        cal_d = CAL_RUN;
      end else begin
        cal_d = CAL_DONE;
      end
    end else begin
      case (cal_q)
        CAL_RUN:  if (cal_finished) cal_d = CAL_DONE;
        CAL_IDLE: cal_d = CAL_IDLE;
        CAL_DONE: cal_d = CAL_DONE;
        default:  cal_d = CAL_IDLE;
      endcase
    end
    start_d = (cal_d == CAL_RUN) && (cal_q != CAL_RUN);
  end

  // synthesizer controls, registered so outputs never glitch
  always_comb begin
    if (ovr_en) begin
      en_d     = ovr_q[EN_BIT];
      se_d     = ovr_q[SE_BIT];
      first_d  = first_fld;
      second_d = second_fld;
    end else begin
      en_d     = sync2_q[PIN_EN];
      se_d     = sync2_q[PIN_SE];
      first_d  = pin_mode;
      second_d = pin_mode;
    end
    if (first_d == MODE_OFF) begin
      second_d = MODE_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ovr_q      <= RST_OVR;
      trim_q     <= RST_TRIM;
      hold_q     <= RST_HOLD;
      rdata_q    <= RD_UNMAP;
      rvalid_q   <= 1'b0;
      cal_q      <= CAL_IDLE;
      start_q    <= 1'b0;
      en_q       <= 1'b0;
      se_q       <= 1'b0;
      first_q    <= MODE_OFF;
      second_q   <= MODE_OFF;
      hold_out_q <= 1'b0;
    end else begin
      ovr_q      <= ovr_d;
      trim_q     <= trim_d;
      hold_q     <= hold_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      cal_q      <= cal_d;
      start_q    <= start_d;
      en_q       <= en_d;
      se_q       <= se_d;
      first_q    <= first_d;
      second_q   <= second_d;
      hold_out_q <= hold_d[HOLD_BIT];
    end
  end

  assign reg_rdata                  = rdata_q;
  assign reg_rvalid                 = rvalid_q;
  assign calibration_start          = start_q;
  assign calibration_done           = (cal_q == CAL_DONE);
  assign synth_enable               = en_q;
  assign single_ended_ref_select    = se_q;
  assign first_divided_refout_mode  = first_q;
  assign second_divided_refout_mode = second_q;
  assign synth_hold                 = hold_out_q;
  assign vco_trim_out               = trim_q[TRIM_W-1:0];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_hold_low_cal;
    wr_hold && !reg_wdata[HOLD_BIT] && calibration_enable;
  endsequence
  sequence s_run_then_finish;
    cal_q == CAL_RUN && cal_finished && !wr_hold;
  endsequence

  AST_SYNTH_EN: assert property (
    synth_enable == ($past(ovr_en) ? $past(ovr_q[EN_BIT])
                                   : $past(sync2_q[PIN_EN])))
    else $error("synth enable source wrong");
  AST_SE_REF: assert property (
    $past(ovr_en) |-> single_ended_ref_select == $past(ovr_q[SE_BIT]))
    else $error("single-ended select not from register");
  AST_FIRST_MODE: assert property (
    $past(ovr_en) |-> first_divided_refout_mode == $past(first_fld))
    else $error("first output mode not from register");
  AST_SECOND_MODE: assert property (
    $past(ovr_en) && $past(first_fld) != MODE_OFF
    |-> second_divided_refout_mode == $past(second_fld))
    else $error("second output mode not from register");
  AST_PIN_MODE: assert property (
    !$past(ovr_en) |-> first_divided_refout_mode == $past(pin_mode))
    else $error("pin mode ignored");
  AST_SECOND_NEEDS_FIRST: assert property (
    first_divided_refout_mode == MODE_OFF
    |-> second_divided_refout_mode == MODE_OFF)
    else $error("second output runs without first");
  AST_TRIM_LOAD: assert property (
    cal_trim_load && cal_q == CAL_RUN
    |=> vco_trim_out == $past(cal_trim_value))
    else $error("calibration trim not loaded");
  AST_TRIM_WRITE: assert property (
    wr_trim && !(cal_trim_load && cal_q == CAL_RUN)
    |=> vco_trim_out == $past(reg_wdata[TRIM_W-1:0]))
    else $error("software trim write lost");
  AST_CAL_START: assert property (
    (s_hold_low_cal and (cal_q != CAL_RUN))
    |=> calibration_start && !calibration_done ##1 !calibration_start)
    else $error("calibration did not start");
  AST_CAL_DONE: assert property (
    s_run_then_finish |=> calibration_done)
    else $error("done not reported after calibration");
  AST_CAL_SKIP: assert property (
    wr_hold && !reg_wdata[HOLD_BIT] && !calibration_enable
    |=> calibration_done)
    else $error("done not reported on skip");

endmodule : spo_ctrl
`default_nettype wire

// ===== hdl/spo_pkg.sv
// constants for the synthesizer pin override control block
package spo_pkg;
  localparam logic [7:0] ADDR_OVR   = 8'h58;
  localparam logic [7:0] ADDR_TRIM  = 8'h59;
  localparam logic [7:0] ADDR_HOLD  = 8'h5C;
  localparam logic [7:0] RST_OVR    = 8'h00;
  localparam logic [7:0] RST_TRIM   = 8'h00;
  localparam logic [7:0] RST_HOLD   = 8'h00;
  localparam logic [7:0] RD_UNMAP   = 8'h00;
  localparam int         OVR_EN_BIT = 7;
  localparam int         SEC_LSB    = 4;
  localparam int         FIRST_LSB  = 2;
  localparam int         SE_BIT     = 1;
  localparam int         EN_BIT     = 0;
  localparam int         HOLD_BIT   = 0;
  localparam int         TRIM_W     = 7;
  localparam int         PIN_W      = 4;
  localparam int         PIN_EN     = 0;
  localparam int         PIN_SE     = 1;
  localparam int         PIN_CFG0   = 2;
  localparam int         PIN_CFG1   = 3;
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [PIN_W-1:0] PIN_RST = 4'h0;
  localparam logic [TRIM_W-1:0] TRIM_RST = 7'h00;
  // calibration sequence, gray along hold -> run -> done
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_RUN  = 2'h1,
    CAL_DONE = 2'h3
  } spo_cal_t;
endpackage : spo_pkg

// ===== verif/spo_host.sv
// host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module spo_host (
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // callers keep reserved bits zero and never touch trim in a run
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  // no answer shows as unknown, so a missing pulse cannot match
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : spo_host
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the pin override control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spo_pkg::*;
  logic       clk_sys, rst_b, pll_enable_pin, ref_select_pin;
  logic       clock_config_pin_zero, clock_config_pin_one;
  logic       calibration_enable, cal_trim_load, cal_finished;
  logic [6:0] cal_trim_value, vco_trim_out;
  logic       reg_wr, reg_rd, reg_rvalid, calibration_start;
  logic       calibration_done, synth_enable, single_ended_ref_select;
  logic       synth_hold;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [1:0] first_divided_refout_mode, second_divided_refout_mode;
  int         error_cnt, n_tests, cyc, n;
  wire  [7:0] outs = {synth_hold, synth_enable, single_ended_ref_select,
    calibration_done, first_divided_refout_mode, second_divided_refout_mode};
  spo_ctrl uut (.clk_sys, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .pll_enable_pin, .ref_select_pin,
    .clock_config_pin_zero, .clock_config_pin_one, .calibration_enable,
    .cal_trim_load, .cal_trim_value, .cal_finished, .calibration_start,
    .calibration_done, .synth_enable, .single_ended_ref_select,
    .first_divided_refout_mode, .second_divided_refout_mode, .synth_hold,
    .vco_trim_out);
  spo_host host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  // samples before each edge, so a pulse lasting one cycle is seen
  task automatic starts();
    n = 0;
    repeat (3) begin
      if (calibration_start === 1'b1) n++;
      step(1);
    end
  endtask : starts
  task automatic pins(input logic [3:0] p);
    {clock_config_pin_one, clock_config_pin_zero} = p[3:2];
    {ref_select_pin, pll_enable_pin} = p[1:0];
    step(4);
  endtask : pins
  task automatic t_reset();
    logic [7:0] a [4] = '{ADDR_OVR, ADDR_TRIM, ADDR_HOLD, 8'h60};
    chk(outs, 8'h00);
    chk({1'b0, vco_trim_out}, 8'h00);
    foreach (a[i]) begin
      host.rd(a[i], v);
      chk(v, 8'h00);
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_pins();
    host.wr(ADDR_OVR, 8'h3E);
    pins(4'hB);
    chk(outs, 8'h6A);
    pins(4'h3);
    chk(outs, 8'h60);
    pins(4'hF);
    chk(outs, 8'h6F);
    $display("test pins done");
  endtask : t_pins
  task automatic t_ovr();
    logic [1:0] f, s;
    for (int i = 0; i < 16; i++) begin
      f = i[1:0];
      s = i[3:2];
      host.wr(ADDR_OVR, {2'b10, s, f, f[0], f[1]});
      step(2);
      chk(outs, {1'b0, f[1], f[0], 1'b0, f, (f == 2'h0) ? 2'h0 : s});
      host.rd(ADDR_OVR, v);
      chk(v, {2'b10, s, f, f[0], f[1]});
    end
    host.wr(ADDR_OVR, 8'h00);
    step(2);
    chk(outs, 8'h6F);
    $display("test override done");
  endtask : t_ovr
  task automatic t_cal();
    host.wr(ADDR_TRIM, 8'h55);
    step(2);
    chk({1'b0, vco_trim_out}, 8'h55);
    calibration_enable = 1'b1;
    host.wr(ADDR_HOLD, 8'h01);
    step(2);
    chk(outs, 8'hEF);
    host.wr(ADDR_HOLD, 8'h00);
    starts();
    chk(8'(n), 8'h01);
    chk(outs, 8'h6F);
    cal_trim_value = 7'h2A;
    cal_trim_load  = 1'b1;
    step(1);
    cal_trim_load  = 1'b0;
    cal_finished   = 1'b1;
    step(1);
    cal_finished   = 1'b0;
    chk(outs, 8'h7F);
    host.rd(ADDR_TRIM, v);
    chk(v, 8'h2A);
    calibration_enable = 1'b0;
    host.wr(ADDR_HOLD, 8'h01);
    step(2);
    chk(outs, 8'hEF);
    host.wr(ADDR_HOLD, 8'h00);
    starts();
    chk(8'(n), 8'h00);
    chk(outs, 8'h7F);
    $display("test calibration done");
  endtask : t_cal
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // ceiling well above the roughly 170 cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_b, pll_enable_pin, ref_select_pin} = 3'h0;
    {clock_config_pin_zero, clock_config_pin_one} = 2'h0;
    {calibration_enable, cal_trim_load, cal_finished} = 3'h0;
    cal_trim_value = 7'h00;
    {error_cnt, n_tests, cyc} = {32'h0, 32'h0, 32'h0};
    step(16);
    rst_b = 1'b1;
    t_reset();
    t_pins();
    t_ovr();
    t_cal();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
